//--- bbc_map.vh
// register map and field layout of the converter and agc configuration bank
`ifndef BBC_MAP_VH
`define BBC_MAP_VH

// printed offsets are register indices; byte address is four times the index
`define BBC_IDX_CLOCK_TEST   8'h18
`define BBC_IDX_POWER_TEST   8'h1A
`define BBC_IDX_FORMAT_OBS   8'h1C
`define BBC_IDX_GAIN_CLIP    8'h1E
`define BBC_IDX_SAT_COUNTS   8'h20
`define BBC_IDX_RF_PAD       8'h22
`define BBC_IDX_HI_SAT       8'h24

`define BBC_RESET_VALUE      8'h00

`define BBC_CLK_SRC_BIT      7
`define BBC_MANUAL_PWR_BIT   0
`define BBC_FORMAT_BIT       7
`define BBC_OBS_SEL_HI       6
`define BBC_OBS_SEL_LO       4
`define BBC_TBUS_DAC_BIT     3
`define BBC_RFADC_DAC_BIT    2

`define BBC_OBS_TX_FILTER    3'h0
`define BBC_OBS_DOWNCONV     3'h1
`define BBC_OBS_CHIP_TIMING  3'h2
`define BBC_OBS_IQ_ADC       3'h3
`define BBC_OBS_PICKER       3'h4
`define BBC_OBS_MF_WEIGHTS   3'h5
`define BBC_OBS_TEST_BUS     3'h6
`define BBC_OBS_CORRELATOR   3'h7

`define BBC_SYNC_PULSE       6'h20

`endif

//--- bbc_cfg.v
// apb register bank steering converter clocks, power, observation dac and agc limits
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "bbc_map.vh"

module bbc_cfg #(
  parameter ACC_W = 16,
  parameter PICK_W = 12,
  parameter MF_N = 16
) (
  input  wire                clk_i,
  input  wire                srst_i,
  input  wire                psel_i,
  input  wire                penable_i,
  input  wire                pwrite_i,
  input  wire [31:0]         paddr_i,
  input  wire [31:0]         pwdata_i,
  input  wire [3:0]          pstrb_i,
  output reg  [31:0]         prdata_o,
  output reg                 pready_o,
  output reg                 pslverr_o,
  input  wire                transmit_power_enable_i,
  input  wire                receive_power_enable_i,
  output reg                 clk_from_serial_data_in_pin_o,
  output reg  [6:0]          conv_clk_run_o,
  output reg                 digital_standby_o,
  output reg                 transmit_sleep_o,
  output reg                 receive_sleep_o,
  output reg                 iq_sleep_o,
  output reg                 analog_tx_shutdown_o,
  output reg                 analog_rx_shutdown_o,
  output reg                 analog_standby_o,
  input  wire [5:0]          i_adc_i,
  input  wire [5:0]          q_adc_i,
  input  wire [5:0]          rf_adc_i,
  output reg  [5:0]          i_adc_o,
  output reg  [5:0]          q_adc_o,
  output reg  [5:0]          rf_adc_o,
  output reg  [1:0]          reference_setting_o,
  input  wire [5:0]          tx_filter_i_i,
  input  wire [5:0]          tx_filter_q_i,
  input  wire [5:0]          downconv_i_i,
  input  wire [5:0]          downconv_q_i,
  input  wire [ACC_W-1:0]    chip_timing_accumulator_i,
  input  wire [PICK_W-1:0]   picker_winner_i_i,
  input  wire [PICK_W-1:0]   picker_winner_q_i,
  input  wire [MF_N*6-1:0]   matched_filter_weights_i,
  input  wire [5:0]          test_bus_i,
  input  wire                test_bus_is_input_i,
  input  wire [5:0]          correlator_i_i,
  input  wire [5:0]          correlator_q_i,
  output reg  [5:0]          obs_dac_i_o,
  output reg  [5:0]          obs_dac_q_o,
  input  wire [5:0]          rx_dac_data_i,
  input  wire [5:0]          tx_dac_data_i,
  output reg  [5:0]          rx_dac_o,
  output reg  [5:0]          tx_dac_o,
  input  wire [8:0]          atten_acc_next_i,
  output reg  [6:0]          atten_acc_o,
  input  wire [4:0]          iq_sat_count_i,
  output reg                 mid_low_step_trigger_o,
  output reg  [3:0]          mid_sat_count_o,
  output reg  [3:0]          low_sat_count_o,
  output reg  [5:0]          rf_pad_db_o,
  output reg  [4:0]          high_sat_step_o
);

  localparam CNT_W = 5;

  reg  [7:0]       converter_clock_test;
  reg  [7:0]       converter_power_test;
  reg  [7:0]       converter_format_observe;
  reg  [7:0]       gain_clip_limit;
  reg  [7:0]       saturation_counts;
  reg  [7:0]       rf_pad_value;
  reg  [7:0]       high_saturation_step;
  reg  [CNT_W-1:0] mf_phase;

  wire [7:0]  idx      = paddr_i[9:2];
  wire        aligned  = (paddr_i[1:0] == 2'h0) && (paddr_i[31:10] == 22'h0);
  wire        setup    = psel_i && !penable_i;
  wire        wr_take  = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
  wire        lane0    = pstrb_i[0];
  reg         hit;
  reg  [7:0]  rd_val;

  // register decode; every bit including unused ones reads back
  always @* begin
    hit = aligned;
    rd_val = 8'h00;
    case (idx)
      `BBC_IDX_CLOCK_TEST: rd_val = converter_clock_test;
      `BBC_IDX_POWER_TEST: rd_val = converter_power_test;
      `BBC_IDX_FORMAT_OBS: rd_val = converter_format_observe;
      `BBC_IDX_GAIN_CLIP:  rd_val = gain_clip_limit;
      `BBC_IDX_SAT_COUNTS: rd_val = saturation_counts;
      `BBC_IDX_RF_PAD:     rd_val = rf_pad_value;
      `BBC_IDX_HI_SAT:     rd_val = high_saturation_step;
      default:             hit = 1'b0;
    endcase
  end

  // no wait state: answer decided in setup, shown in the first access cycle
  always @(posedge clk_i) begin
    if (srst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else if (setup) begin
      pready_o  <= 1'b1;
      pslverr_o <= !hit;
      prdata_o  <= (hit && !pwrite_i) ? {24'h000000, rd_val} : 32'h00000000;
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // writes land only on the accepted access edge, low byte lane
  always @(posedge clk_i) begin
    if (srst_i) begin
      converter_clock_test     <= `BBC_RESET_VALUE;
      converter_power_test     <= `BBC_RESET_VALUE;
      converter_format_observe <= `BBC_RESET_VALUE;
      gain_clip_limit          <= `BBC_RESET_VALUE;
      saturation_counts        <= `BBC_RESET_VALUE;
      rf_pad_value             <= `BBC_RESET_VALUE;
      high_saturation_step     <= `BBC_RESET_VALUE;
    end else if (wr_take && lane0) begin
      case (idx)
        `BBC_IDX_CLOCK_TEST: converter_clock_test     <= pwdata_i[7:0];
        `BBC_IDX_POWER_TEST: converter_power_test     <= pwdata_i[7:0];
        `BBC_IDX_FORMAT_OBS: converter_format_observe <= pwdata_i[7:0];
        `BBC_IDX_GAIN_CLIP:  gain_clip_limit          <= pwdata_i[7:0];
        `BBC_IDX_SAT_COUNTS: saturation_counts        <= pwdata_i[7:0];
        `BBC_IDX_RF_PAD:     rf_pad_value             <= pwdata_i[7:0];
        `BBC_IDX_HI_SAT:     high_saturation_step     <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end

  // converter clocking
  always @(posedge clk_i) begin
    if (srst_i) begin
      clk_from_serial_data_in_pin_o <= 1'b0;
      conv_clk_run_o                <= 7'h7F;
    end else begin
      clk_from_serial_data_in_pin_o <= converter_clock_test[`BBC_CLK_SRC_BIT];
      conv_clk_run_o                <= ~converter_clock_test[6:0];
    end
  end

  // power controls; reset itself counts as the automatic standby cause
  wire manual = converter_power_test[`BBC_MANUAL_PWR_BIT];
  wire transmit_power_enable  = transmit_power_enable_i;
  wire receive_power_enable  = receive_power_enable_i;
  always @(posedge clk_i) begin
    if (srst_i) begin
      digital_standby_o    <= 1'b1;
      transmit_sleep_o     <= 1'b1;
      receive_sleep_o      <= 1'b1;
      iq_sleep_o           <= 1'b1;
      analog_tx_shutdown_o <= 1'b1;
      analog_rx_shutdown_o <= 1'b1;
      analog_standby_o     <= 1'b1;
    end else if (manual) begin
      digital_standby_o    <= converter_power_test[7];
      transmit_sleep_o     <= converter_power_test[6];
      receive_sleep_o      <= converter_power_test[5];
      iq_sleep_o           <= converter_power_test[4];
      analog_tx_shutdown_o <= converter_power_test[3];
      analog_rx_shutdown_o <= converter_power_test[2];
      analog_standby_o     <= converter_power_test[1];
    end else begin
      digital_standby_o    <= 1'b0;
      transmit_sleep_o     <= !transmit_power_enable;
      receive_sleep_o      <= !receive_power_enable;
      iq_sleep_o           <= !(transmit_power_enable || receive_power_enable);
      analog_tx_shutdown_o <= !transmit_power_enable;
      analog_rx_shutdown_o <= !receive_power_enable;
      analog_standby_o     <= !(transmit_power_enable || receive_power_enable);
    end
  end

  // offset binary is two's complement with the sign bit inverted
  wire fmt = converter_format_observe[`BBC_FORMAT_BIT];
  always @(posedge clk_i) begin
    if (srst_i) begin
      i_adc_o             <= 6'h00;
      q_adc_o             <= 6'h00;
      rf_adc_o            <= 6'h00;
      reference_setting_o <= 2'h0;
    end else begin
      i_adc_o             <= {i_adc_i[5] ^ fmt, i_adc_i[4:0]};
      q_adc_o             <= {q_adc_i[5] ^ fmt, q_adc_i[4:0]};
      rf_adc_o            <= {rf_adc_i[5] ^ fmt, rf_adc_i[4:0]};
      reference_setting_o <= converter_format_observe[1:0];
    end
  end

  // weight rotation: even phases carry the sync pulse, odd ones a weight
  always @(posedge clk_i) begin
    if (srst_i) begin
      mf_phase <= {CNT_W{1'b0}};
    end else begin
      mf_phase <= mf_phase + 1'b1;
    end
  end

  wire [2:0] obs_sel = converter_format_observe[`BBC_OBS_SEL_HI:`BBC_OBS_SEL_LO];
  wire [3:0] mf_idx  = mf_phase[CNT_W-1:1];
  wire [5:0] mf_word = matched_filter_weights_i[mf_idx*6 +: 6];
  reg  [5:0] next_obs_i;
  reg  [5:0] next_obs_q;

  always @* begin
    next_obs_i = 6'h00;
    next_obs_q = 6'h00;
    case (obs_sel)
      `BBC_OBS_TX_FILTER: begin
        next_obs_i = tx_filter_i_i;
        next_obs_q = tx_filter_q_i;
      end
      `BBC_OBS_DOWNCONV: begin
        next_obs_i = downconv_i_i;
        next_obs_q = downconv_q_i;
      end
      `BBC_OBS_CHIP_TIMING: begin
        next_obs_i = 6'h00;
        next_obs_q = chip_timing_accumulator_i[ACC_W-1:ACC_W-6];
      end
      `BBC_OBS_IQ_ADC: begin
        next_obs_i = i_adc_i;
        next_obs_q = q_adc_i;
      end
      `BBC_OBS_PICKER: begin
        next_obs_i = picker_winner_i_i[PICK_W-1:PICK_W-6];
        next_obs_q = picker_winner_q_i[PICK_W-1:PICK_W-6];
      end
      `BBC_OBS_MF_WEIGHTS: begin
        next_obs_i = mf_phase[0] ? mf_word : `BBC_SYNC_PULSE;
        next_obs_q = mf_phase[0] ? mf_word : `BBC_SYNC_PULSE;
      end
      `BBC_OBS_TEST_BUS: begin
        // only meaningful while the test bus pins are inputs
        next_obs_i = test_bus_is_input_i ? test_bus_i : 6'h00;
        next_obs_q = test_bus_is_input_i ? test_bus_i : 6'h00;
      end
      `BBC_OBS_CORRELATOR: begin
        next_obs_i = correlator_i_i;
        next_obs_q = correlator_q_i;
      end
      default: begin
        next_obs_i = 6'h00;
        next_obs_q = 6'h00;
      end
    endcase
  end

  wire rfadc_to_rx = converter_format_observe[`BBC_RFADC_DAC_BIT];
  wire tbus_to_dac = converter_format_observe[`BBC_TBUS_DAC_BIT] && !rfadc_to_rx;

  always @(posedge clk_i) begin
    if (srst_i) begin
      obs_dac_i_o <= 6'h00;
      obs_dac_q_o <= 6'h00;
      rx_dac_o    <= 6'h00;
      tx_dac_o    <= 6'h00;
    end else begin
      obs_dac_i_o <= next_obs_i;
      obs_dac_q_o <= next_obs_q;
      // rf adc path wins over the test bus path
      rx_dac_o    <= rfadc_to_rx ? rf_adc_i : (tbus_to_dac ? test_bus_i : rx_dac_data_i);
      tx_dac_o    <= tbus_to_dac ? test_bus_i : tx_dac_data_i;
    end
  end

  // agc limits; negative requests are signed and clamp to zero
  wire [6:0] clip     = gain_clip_limit[6:0];
  wire       acc_neg  = atten_acc_next_i[8];
  wire       acc_over = !acc_neg && (atten_acc_next_i[7:0] > {1'b0, clip});
  wire [3:0] hi_count = high_saturation_step[3:0];

  always @(posedge clk_i) begin
    if (srst_i) begin
      atten_acc_o            <= 7'h00;
      mid_low_step_trigger_o <= 1'b0;
      mid_sat_count_o        <= 4'h0;
      low_sat_count_o        <= 4'h0;
      rf_pad_db_o            <= 6'h00;
      high_sat_step_o        <= 5'h00;
    end else begin
      atten_acc_o            <= acc_neg ? 7'h00 :
                                (acc_over ? clip : atten_acc_next_i[6:0]);
      mid_low_step_trigger_o <= iq_sat_count_i > {1'b0, saturation_counts[7:4]};
      mid_sat_count_o        <= saturation_counts[7:4];
      low_sat_count_o        <= saturation_counts[3:0];
      rf_pad_db_o            <= rf_pad_value[5:0];
      high_sat_step_o        <= (iq_sat_count_i > {1'b0, hi_count}) ?
                                {high_saturation_step[7:4], 1'b0} : 5'h00;
    end
  end

endmodule
`default_nettype wire

//--- bbc_cfg_properties.sv
// concurrent checks on the converter and agc configuration bank ports
`timescale 1ns/1ps
`default_nettype none
module bbc_cfg_properties (
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        clk_from_serial_data_in_pin_o,
  input wire logic [6:0]  conv_clk_run_o,
  input wire logic        digital_standby_o,
  input wire logic        transmit_sleep_o,
  input wire logic        receive_sleep_o,
  input wire logic        iq_sleep_o,
  input wire logic        analog_tx_shutdown_o,
  input wire logic        analog_rx_shutdown_o,
  input wire logic        analog_standby_o,
  input wire logic [5:0]  rf_adc_i,
  input wire logic [5:0]  rf_adc_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  sequence wr_s(logic [31:0] a);
    psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && paddr_i == a;
  endsequence
  a_ready_follows: assert property (setup_s |=> pready_o)
    else $error("no ready after setup");
  a_ready_cause: assert property (pready_o |-> $past(psel_i && !penable_i))
    else $error("ready without setup");
  a_clock_source: assert property (
    wr_s(32'h60) |=> ##1 clk_from_serial_data_in_pin_o == $past(pwdata_i[7], 2))
    else $error("clock source not from register");
  a_clock_gates: assert property (wr_s(32'h60) |=> ##1 conv_clk_run_o == ~$past(pwdata_i[6:0], 2))
    else $error("clock gates wrong");
  a_manual_power: assert property (wr_s(32'h68) ##0 pwdata_i[0] |=> ##1
    {digital_standby_o, transmit_sleep_o, receive_sleep_o, iq_sleep_o, analog_tx_shutdown_o,
     analog_rx_shutdown_o, analog_standby_o} == $past(pwdata_i[7:1], 2))
    else $error("manual power controls wrong");
  a_adc_low_bits: assert property (!$past(srst_i) |-> rf_adc_o[4:0] == $past(rf_adc_i[4:0]))
    else $error("adc low bits altered");
  a_err_misaligned: assert property (setup_s ##0 paddr_i[1:0] != 2'h0 |=> pslverr_o && pready_o)
    else $error("misaligned access not refused");
  a_err_no_data: assert property (pslverr_o |-> prdata_o == 32'h0)
    else $error("read data on refused access");
  a_reset_values: assert property ($past(srst_i) |-> conv_clk_run_o == 7'h7F && digital_standby_o)
    else $error("reset state wrong");
endmodule
bind bbc_cfg bbc_cfg_properties u_props (.clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .clk_from_serial_data_in_pin_o,
  .conv_clk_run_o, .digital_standby_o, .transmit_sleep_o, .receive_sleep_o, .iq_sleep_o,
  .analog_tx_shutdown_o, .analog_rx_shutdown_o, .analog_standby_o, .rf_adc_i, .rf_adc_o);
`default_nettype wire

//--- tb.sv
// self-checking bench for the converter and agc configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, er;
  logic transmit_power_enable_i = 0, receive_power_enable_i = 0, test_bus_is_input_i = 1;
  logic [31:0] paddr_i = 0, pwdata_i = 0, prdata_o, rd, n, s;
  logic [3:0] pstrb_i = 4'hF, mid_sat_count_o, low_sat_count_o;
  logic pready_o, pslverr_o, clk_from_serial_data_in_pin_o, digital_standby_o, transmit_sleep_o;
  logic receive_sleep_o, iq_sleep_o, analog_tx_shutdown_o, analog_rx_shutdown_o, analog_standby_o;
  logic mid_low_step_trigger_o;
  logic [6:0] conv_clk_run_o, atten_acc_o;
  logic [5:0] i_adc_i, q_adc_i, rf_adc_i, tx_filter_i_i, tx_filter_q_i, downconv_i_i, downconv_q_i;
  logic [5:0] test_bus_i, correlator_i_i, correlator_q_i, rx_dac_data_i, tx_dac_data_i;
  logic [5:0] i_adc_o, q_adc_o, rf_adc_o, obs_dac_i_o, obs_dac_q_o, rx_dac_o, tx_dac_o, rf_pad_db_o;
  logic [1:0] reference_setting_o;
  logic [15:0] chip_timing_accumulator_i;
  logic [11:0] picker_winner_i_i, picker_winner_q_i;
  logic [95:0] matched_filter_weights_i;
  logic [8:0] atten_acc_next_i = 0;
  logic [4:0] iq_sat_count_i = 0, high_sat_step_o;
  int mismatches = 0, checked = 0, cycles = 0;
  wire [6:0] pw = {digital_standby_o, transmit_sleep_o, receive_sleep_o, iq_sleep_o,
                   analog_tx_shutdown_o, analog_rx_shutdown_o, analog_standby_o};
  bbc_cfg u_bbc_cfg (.clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .transmit_power_enable_i, .receive_power_enable_i,
    .clk_from_serial_data_in_pin_o, .conv_clk_run_o, .digital_standby_o, .transmit_sleep_o,
    .receive_sleep_o, .iq_sleep_o, .analog_tx_shutdown_o, .analog_rx_shutdown_o,
    .analog_standby_o, .i_adc_i, .q_adc_i, .rf_adc_i, .i_adc_o, .q_adc_o, .rf_adc_o,
    .reference_setting_o, .tx_filter_i_i, .tx_filter_q_i, .downconv_i_i, .downconv_q_i,
    .chip_timing_accumulator_i, .picker_winner_i_i, .picker_winner_q_i, .matched_filter_weights_i,
    .test_bus_i, .test_bus_is_input_i, .correlator_i_i, .correlator_q_i, .obs_dac_i_o,
    .obs_dac_q_o, .rx_dac_data_i, .tx_dac_data_i, .rx_dac_o, .tx_dac_o, .atten_acc_next_i,
    .atten_acc_o, .iq_sat_count_i, .mid_low_step_trigger_o, .mid_sat_count_o, .low_sat_count_o,
    .rf_pad_db_o, .high_sat_step_o);
  always #4 clk_i = ~clk_i;
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // idle cycle first, so a release and a new setup never share a time step
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic rnd;
    {i_adc_i, q_adc_i, rf_adc_i, tx_filter_i_i, tx_filter_q_i, downconv_i_i} <= 36'({$urandom, $urandom});
    {downconv_q_i, test_bus_i, correlator_i_i, correlator_q_i, rx_dac_data_i, tx_dac_data_i} <=
      36'({$urandom, $urandom});
    {chip_timing_accumulator_i, picker_winner_i_i, picker_winner_q_i} <= 40'({$urandom, $urandom});
    matched_filter_weights_i <= {$urandom, $urandom, $urandom};
  endtask
  function automatic logic [11:0] obs_exp(input logic [2:0] c);
    case (c)
      3'h0: return {tx_filter_i_i, tx_filter_q_i};
      3'h1: return {downconv_i_i, downconv_q_i};
      3'h2: return {6'h0, chip_timing_accumulator_i[15:10]};
      3'h3: return {i_adc_i, q_adc_i};
      3'h4: return {picker_winner_i_i[11:6], picker_winner_q_i[11:6]};
      3'h6: return {test_bus_i, test_bus_i};
      default: return {correlator_i_i, correlator_q_i};
    endcase
  endfunction
  // negative requests floor at zero
  function automatic logic [6:0] clamp(input logic [8:0] a, input logic [6:0] c);
    if (a[8]) return 7'h0;
    return (a[7:0] > {1'b0, c}) ? c : a[6:0];
  endfunction
  initial begin
    logic [7:0] v;
    void'($urandom(32'h8B62D24D));
    rnd();
    repeat (12) @(posedge clk_i);
    srst_i <= 0;
    cmp({conv_clk_run_o, pw}, 14'h3FFF);
    for (int k = 0; k < 7; k++) begin
      v = 8'($urandom);
      apb(1, 32'h60 + 8 * k, v);
      apb(0, 32'h60 + 8 * k, 8'h0);
      cmp(rd, {24'h0, v});
    end
    apb(1, 32'h64, 8'hFF);
    cmp(er, 1);
    apb(0, 32'h62, 8'h0);
    cmp({er, rd[30:0]}, 32'h80000000);
    repeat (2) begin
      v = 8'($urandom);
      apb(1, 32'h60, v);
      settle();
      cmp({clk_from_serial_data_in_pin_o, conv_clk_run_o}, {v[7], ~v[6:0]});
    end
    v = 8'($urandom) | 8'h01;
    apb(1, 32'h68, v);
    settle();
    cmp(pw, v[7:1]);
    apb(1, 32'h68, 8'hFE); // bits ignored while automatic
    for (int k = 0; k < 4; k++) begin
      {transmit_power_enable_i, receive_power_enable_i} <= k[1:0];
      settle();
      cmp(pw, {1'b0, ~k[1], ~k[0], ~|k[1:0], ~k[1], ~k[0], ~|k[1:0]});
    end
    for (int k = 0; k < 2; k++) begin
      apb(1, 32'h70, {k[0], 5'h0, k[0], 1'b1});
      rnd();
      settle();
      cmp(reference_setting_o, {k[0], 1'b1});
      cmp({rf_adc_o, i_adc_o, q_adc_o}, {rf_adc_i, i_adc_i, q_adc_i} ^ {k[0], 5'h0, k[0], 5'h0, k[0], 5'h0});
    end
    for (int k = 0; k < 8; k++) begin
      apb(1, 32'h70, {1'b0, 3'(k), 4'h0});
      rnd();
      settle();
      if (k != 5) cmp({obs_dac_i_o, obs_dac_q_o}, obs_exp(3'(k)));
    end
    // test bus pins driven as outputs must not leak into the observation dac
    test_bus_is_input_i <= 0;
    apb(1, 32'h70, 8'h60);
    settle();
    cmp({obs_dac_i_o, obs_dac_q_o}, 12'h000);
    test_bus_is_input_i <= 1;
    for (int k = 0; k < 16; k++) matched_filter_weights_i[6 * k +: 6] <= 6'(k);
    apb(1, 32'h70, 8'h50);
    settle();
    n = 0;
    s = 0;
    repeat (32) begin
      @(posedge clk_i);
      if (obs_dac_q_o === 6'h20) n++;
      else s = s + obs_dac_q_o;
    end
    cmp(n, 32'd16);
    cmp(s, 32'd120);
    for (int k = 0; k < 4; k++) begin
      apb(1, 32'h70, {4'h0, k[1:0], 2'h0});
      rnd();
      settle();
      cmp({rx_dac_o, tx_dac_o}, {k[0] ? rf_adc_i : k[1] ? test_bus_i : rx_dac_data_i,
                                 (k[1] & !k[0]) ? test_bus_i : tx_dac_data_i});
    end
    // first round pins every count at full scale, the strict compare edge
    for (int k = 0; k < 8; k++) begin
      v = (k == 0) ? 8'hFF : 8'($urandom);
      for (int r = 0; r < 4; r++) apb(1, 32'h78 + 8 * r, v);
      atten_acc_next_i <= (k == 0) ? 9'h1FF : 9'($urandom);
      iq_sat_count_i <= (k == 0) ? 5'h0F : 5'($urandom);
      settle();
      cmp(atten_acc_o, clamp(atten_acc_next_i, v[6:0]));
      cmp({mid_sat_count_o, low_sat_count_o, rf_pad_db_o}, {v, v[5:0]});
      cmp(mid_low_step_trigger_o, iq_sat_count_i > {1'b0, v[7:4]});
      cmp(high_sat_step_o, (iq_sat_count_i > {1'b0, v[3:0]}) ? {v[7:4], 1'b0} : 5'h0);
    end
    summarize();
  end
endmodule
`default_nettype wire
